// ===== src/mcpc_pkg.sv
// package: register number, field positions, reset values and carriers for the control bank
package mcpc_pkg;
	localparam logic [9:0] HW_IMPL_CONTROL_0_SPR = 10'h3f0; // spr number 1008
	localparam int MC_PIN_ENABLE_BIT = 0;
	localparam int PARITY_GEN_DISABLE_BIT = 1;
	localparam int ADDR_PARITY_CHECK_ENABLE_BIT = 2;
	localparam int DATA_PARITY_CHECK_ENABLE_BIT = 3;
	localparam int RESERVED_A_BIT = 4;
	localparam int UNUSED_BIT = 5;
	localparam int RESERVED_B_BIT = 6;
	localparam int RETRY_PRECHARGE_DISABLE_BIT = 7;
	localparam int DOZE_ENABLE_BIT = 8;
	localparam logic [8:0] CTRL_RESET = 9'h000;
	localparam logic [8:0] CTRL_IMPL_MASK = 9'h18f; // bits 0..3, 7, 8 are stored
	localparam int SAVE_RESTORE_STATUS_1_MCPIN_BIT = 12;
	localparam int SAVE_RESTORE_STATUS_1_DATA_PARITY_BIT = 14;
	localparam int SAVE_RESTORE_STATUS_1_ADDR_PARITY_BIT = 15;
	localparam logic [31:0] SAVE_RESTORE_STATUS_1_RESET = 32'h0000_0000;

	// move-to / move-from special register request
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [9:0] sprNum;
		logic [31:0] wrData;
	} mcpc_spr_req_t;

	// error reporting toward the exception unit
	typedef struct packed {
		logic mcException;
		logic checkstop;
		logic [31:0] srr1Bits;
	} mcpc_err_t;

	// bus pin controls
	typedef struct packed {
		logic parityGenEnable;
		logic addrParityRxEnable;
		logic dataParityRxEnable;
		logic retryPrechargeEnable;
	} mcpc_bus_ctl_t;
endpackage

// ===== src/mcpc_ctrl.sv
// machine check, bus parity, retry precharge and doze control bank
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: register is spr 1008, read and write
// RQ2: pin enable clear ignores machine check pin
// RQ3: enabled pin: checkstop or exception by enable
// RQ4: bit 1 set stops parity generation
// RQ5: no generation, no check: receivers off
// RQ6: software disables checks without generation
// RQ7: bit 2 enables address parity checking
// RQ8: bit 3 enables data parity checking
// RQ9: software writes zero to bits 4, 6
// RQ10: bit 5 has no function
// RQ11: bit 7 stops retry high precharge
// RQ12: system restores retry high when disabled
// RQ13: bit 8 with power request enters doze
// RQ14: doze keeps pll, time base, snoop running
// RQ15: pin machine check sets status bit 12
// RQ16: data parity error sets status bit 14
// RQ17: address parity error sets status bit 15
// RQ18: reads return stored bits, writes take effect
module mcpc_ctrl (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire mcpc_pkg::mcpc_spr_req_t sprReq,
	output logic [31:0] sprRdData,
	output logic sprRdValid,
	input wire logic machineCheckPin,
	input wire logic addrParityErr,
	input wire logic dataParityErr,
	input wire logic mcExceptionEnable,
	input wire logic lowEnergyRequest,
	output mcpc_pkg::mcpc_err_t errOut,
	output mcpc_pkg::mcpc_bus_ctl_t busCtl,
	output logic dozeActive,
	output logic pllRun,
	output logic timeBaseRun,
	output logic snoopRun
);
	import mcpc_pkg::*;

	logic [8:0] ctrl, next_ctrl;
	logic [31:0] rdData, next_rdData;
	logic rdValid, next_rdValid;
	logic [2:0] pinSync, next_pinSync;
	logic [2:0] runOn, next_runOn;
	logic pinStable, next_pinStable;
	mcpc_err_t err, next_err;
	mcpc_bus_ctl_t bus, next_bus;
	logic doze, next_doze;
	logic pinRise, errEvent;

	wire sprHit = (sprReq.sprNum == HW_IMPL_CONTROL_0_SPR); // RQ1

	// register write and read-back; reserved/unused bits are not stored and read zero
	always_comb begin
		next_ctrl = ctrl;
		next_rdValid = sprReq.rdEn;
		next_rdData = 32'h0000_0000;
		if (sprReq.wrEn && sprHit) begin
			next_ctrl = sprReq.wrData[8:0] & CTRL_IMPL_MASK; // RQ18 RQ10
		end
		if (sprReq.rdEn && sprHit) begin
			next_rdData = {23'h000000, ctrl}; // RQ18 RQ1
		end
	end

	// pin crosses from outside: three stages, change accepted when stage 2 and 3 agree
	always_comb begin
		next_pinSync = {pinSync[1:0], machineCheckPin};
		next_pinStable = pinStable;
		if (pinSync[1] == pinSync[2]) begin
			next_pinStable = pinSync[2];
		end
	end
	assign pinRise = next_pinStable && !pinStable;

	// error routing: each source gated by its enable, me picks exception or checkstop
	always_comb begin
		logic pinHit;
		logic apHit;
		logic dpHit;
		pinHit = pinRise && ctrl[MC_PIN_ENABLE_BIT]; // RQ2
		apHit = addrParityErr && ctrl[ADDR_PARITY_CHECK_ENABLE_BIT]; // RQ7
		dpHit = dataParityErr && ctrl[DATA_PARITY_CHECK_ENABLE_BIT]; // RQ8
		errEvent = pinHit || apHit || dpHit;
		next_err = '0;
		next_err.mcException = errEvent && mcExceptionEnable; // RQ3 RQ7 RQ8
		next_err.checkstop = errEvent && !mcExceptionEnable; // RQ3 RQ7 RQ8
		next_err.srr1Bits[SAVE_RESTORE_STATUS_1_MCPIN_BIT] = pinHit && mcExceptionEnable; // RQ15
		next_err.srr1Bits[SAVE_RESTORE_STATUS_1_DATA_PARITY_BIT] = dpHit && mcExceptionEnable; // RQ16
		next_err.srr1Bits[SAVE_RESTORE_STATUS_1_ADDR_PARITY_BIT] = apHit && mcExceptionEnable; // RQ17
	end

	// bus pin controls follow the stored bits
	always_comb begin
		logic genOn;
		genOn = !ctrl[PARITY_GEN_DISABLE_BIT];
		next_bus.parityGenEnable = genOn; // RQ4
		// each receiver only off when nothing generates and its own parity check is off
		next_bus.addrParityRxEnable = genOn || ctrl[ADDR_PARITY_CHECK_ENABLE_BIT]; // RQ5
		next_bus.dataParityRxEnable = genOn || ctrl[DATA_PARITY_CHECK_ENABLE_BIT]; // RQ5
		// when off the system must pull retry high itself
		next_bus.retryPrechargeEnable = !ctrl[RETRY_PRECHARGE_DISABLE_BIT]; // RQ11 RQ12
	end

	// doze: entered on power request with doze bit; left when request drops or bit clears
	always_comb begin
		next_doze = ctrl[DOZE_ENABLE_BIT] && lowEnergyRequest; // RQ13
	end

	// nap and sleep live outside this bank, so nothing here ever stops these;
	// doze in particular must leave them running
	always_comb begin
		next_runOn = 3'h7; // RQ14
	end

	// register bank: stored control bits and the read answer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= CTRL_RESET;
			rdData <= 32'h0000_0000;
			rdValid <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			rdData <= next_rdData;
			rdValid <= next_rdValid;
		end
	end

	// pin synchroniser; first stage feeds only the second
	// reset low matches the idle pin, so no false edge follows reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pinSync <= 3'h0;
			pinStable <= 1'b0;
		end else begin
			pinSync <= next_pinSync;
			pinStable <= next_pinStable;
		end
	end

	// error strobes, one cycle per event cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			err <= '0;
		end else begin
			err <= next_err;
		end
	end

	// bus controls reset to what an all-zero ctrl asks for: everything on
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus <= '{1'b1, 1'b1, 1'b1, 1'b1};
			doze <= 1'b0;
			runOn <= 3'h7;
		end else begin
			bus <= next_bus;
			doze <= next_doze;
			runOn <= next_runOn;
		end
	end

	assign sprRdData = rdData;
	assign sprRdValid = rdValid;
	assign errOut = err;
	assign busCtl = bus;
	assign dozeActive = doze;
	// each run flag has its own flop so the outputs stay glitch free
	assign pllRun = runOn[2]; // RQ14
	assign timeBaseRun = runOn[1]; // RQ14
	assign snoopRun = runOn[0]; // RQ14

	AST_PIN_MASKED: assert property (@(posedge sys_clk) disable iff (!nrst)
		(!ctrl[MC_PIN_ENABLE_BIT] && !addrParityErr && !dataParityErr) |=> (err.srr1Bits[SAVE_RESTORE_STATUS_1_MCPIN_BIT] == 1'b0))
		else $error("masked pin raised status"); // RQ2
	AST_CHECKSTOP_NO_ME: assert property (@(posedge sys_clk) disable iff (!nrst)
		(addrParityErr && ctrl[ADDR_PARITY_CHECK_ENABLE_BIT] && !mcExceptionEnable) |=> err.checkstop)
		else $error("address error without me must checkstop"); // RQ7
	AST_DP_EXC: assert property (@(posedge sys_clk) disable iff (!nrst)
		(dataParityErr && ctrl[DATA_PARITY_CHECK_ENABLE_BIT] && mcExceptionEnable)
		|=> (err.mcException && err.srr1Bits[SAVE_RESTORE_STATUS_1_DATA_PARITY_BIT]))
		else $error("data parity exception missing"); // RQ16
	AST_AP_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ctrl[ADDR_PARITY_CHECK_ENABLE_BIT] |=> !err.srr1Bits[SAVE_RESTORE_STATUS_1_ADDR_PARITY_BIT])
		else $error("address parity flagged while disabled"); // RQ17
	AST_PIN_EXC: assert property (@(posedge sys_clk) disable iff (!nrst)
		(pinRise && ctrl[MC_PIN_ENABLE_BIT] && mcExceptionEnable) |=> err.srr1Bits[SAVE_RESTORE_STATUS_1_MCPIN_BIT])
		else $error("pin exception status missing"); // RQ15
	AST_PARGEN: assert property (@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> (busCtl.parityGenEnable == !$past(ctrl[PARITY_GEN_DISABLE_BIT])))
		else $error("parity generation mismatch"); // RQ4
	AST_RX_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
		(ctrl[PARITY_GEN_DISABLE_BIT] && !ctrl[DATA_PARITY_CHECK_ENABLE_BIT]) |=> !busCtl.dataParityRxEnable)
		else $error("data receivers left on"); // RQ5
	AST_PRECHARGE: assert property (@(posedge sys_clk) disable iff (!nrst)
		ctrl[RETRY_PRECHARGE_DISABLE_BIT] |=> !busCtl.retryPrechargeEnable)
		else $error("retry precharge while disabled"); // RQ11
	AST_DOZE: assert property (@(posedge sys_clk) disable iff (!nrst)
		(ctrl[DOZE_ENABLE_BIT] && lowEnergyRequest) |=> (dozeActive && pllRun && snoopRun))
		else $error("doze entry wrong"); // RQ13
	AST_READBACK: assert property (@(posedge sys_clk) disable iff (!nrst)
		(sprReq.wrEn && sprHit && !sprReq.rdEn) ##1 (sprReq.rdEn && sprHit && !sprReq.wrEn)
		|=> (sprRdData[8:0] == ($past(sprReq.wrData, 2) & CTRL_IMPL_MASK[8:0])))
		else $error("read back mismatch"); // RQ18
	AST_PIN_CHECKSTOP: assert property (@(posedge sys_clk) disable iff (!nrst)
		(pinRise && ctrl[MC_PIN_ENABLE_BIT] && !mcExceptionEnable) |=> (err.checkstop && !err.mcException))
		else $error("pin without me must checkstop"); // RQ3
	AST_RX_ADDR_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
		(ctrl[PARITY_GEN_DISABLE_BIT] && !ctrl[ADDR_PARITY_CHECK_ENABLE_BIT]) |=> !busCtl.addrParityRxEnable)
		else $error("address receivers left on"); // RQ5
	AST_DOZE_OFF: assert property (@(posedge sys_clk) disable iff (!nrst)
		!ctrl[DOZE_ENABLE_BIT] |=> !dozeActive)
		else $error("doze while disabled"); // RQ13
	AST_RUN_KEPT: assert property (@(posedge sys_clk) disable iff (!nrst)
		dozeActive |-> (pllRun && timeBaseRun && snoopRun))
		else $error("clock or snoop stopped in doze"); // RQ14
	AST_UNUSED_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
		sprRdValid |-> !(sprRdData[RESERVED_A_BIT] || sprRdData[UNUSED_BIT] || sprRdData[RESERVED_B_BIT]))
		else $error("unused bit read back set"); // RQ10
	AST_OTHER_SPR: assert property (@(posedge sys_clk) disable iff (!nrst)
		(sprReq.rdEn && !sprHit) |=> (sprRdData == 32'h0000_0000))
		else $error("other register number answered"); // RQ1
	COV_CHECKSTOP: cover property (@(posedge sys_clk) err.checkstop);
	COV_PIN_EXC: cover property (@(posedge sys_clk) err.srr1Bits[SAVE_RESTORE_STATUS_1_MCPIN_BIT]);
	COV_DOZE: cover property (@(posedge sys_clk) dozeActive);
	COV_NO_RX: cover property (@(posedge sys_clk) !busCtl.addrParityRxEnable);
	COV_READBACK: cover property (@(posedge sys_clk) (sprReq.wrEn && sprHit) ##1 (sprReq.rdEn && sprHit));
endmodule
`default_nettype wire

// ===== dv/mcpc_sys_model.sv
// system bus model: machine check pin, parity error strobes, retry restore
`timescale 1ns/1ps
`default_nettype none
module mcpc_sys_model (
	input wire logic sys_clk,
	output logic machineCheckPin,
	output logic addrParityErr,
	output logic dataParityErr,
	output logic addrRetry
);
	import mcpc_pkg::*;
	// idle lines low so no event is seen by accident
	initial {machineCheckPin, addrParityErr, dataParityErr} = 3'b000;
	// system logic drives retry back high itself, precharge or not
	assign addrRetry = 1'b1;
	// pin held four edges so the synchroniser cannot miss it
	task automatic pulse(input int k);
		@(posedge sys_clk);
		case (k)
			0: machineCheckPin <= 1'b1;
			1: addrParityErr <= 1'b1;
			default: dataParityErr <= 1'b1;
		endcase
		repeat (k == 0 ? 4 : 1) @(posedge sys_clk);
		{machineCheckPin, addrParityErr, dataParityErr} <= 3'b000;
	endtask
endmodule
`default_nettype wire

// ===== dv/mcpc_ctrl_tb.sv
// self-checking bench for the machine check and parity control bank
`timescale 1ns/1ps
`default_nettype none
module mcpc_ctrl_tb;
	import mcpc_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic meEn = 1'b0;
	logic lowReq = 1'b0;
	mcpc_spr_req_t sprReq = '0;
	logic [31:0] sprRdData;
	logic sprRdValid, mcPin, apErr, dpErr, dozeActive, pllRun, timeBaseRun, snoopRun, addrRetry;
	mcpc_err_t errOut;
	mcpc_bus_ctl_t busCtl;
	int fails = 0;
	int n_compared = 0;
	always #5 sys_clk = ~sys_clk;
	mcpc_ctrl uut (.sys_clk(sys_clk), .nrst(nrst), .sprReq(sprReq), .sprRdData(sprRdData),
		.sprRdValid(sprRdValid), .machineCheckPin(mcPin), .addrParityErr(apErr),
		.dataParityErr(dpErr), .mcExceptionEnable(meEn), .lowEnergyRequest(lowReq),
		.errOut(errOut), .busCtl(busCtl), .dozeActive(dozeActive), .pllRun(pllRun),
		.timeBaseRun(timeBaseRun), .snoopRun(snoopRun));
	mcpc_sys_model sys (.sys_clk(sys_clk), .machineCheckPin(mcPin), .addrParityErr(apErr),
		.dataParityErr(dpErr), .addrRetry(addrRetry));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// extra edge after the write so pin controls have settled
	task automatic wr(input logic [9:0] num, input logic [31:0] d);
		@(posedge sys_clk);
		sprReq <= '{1'b1, 1'b0, num, d};
		@(posedge sys_clk);
		sprReq.wrEn <= 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [9:0] num, input logic [31:0] exp);
		@(posedge sys_clk);
		sprReq <= '{1'b0, 1'b1, num, 32'h0000_0000};
		@(posedge sys_clk);
		sprReq.rdEn <= 1'b0;
		#1;
		chk({31'h0, sprRdValid}, 32'h0000_0001);
		chk(sprRdData, exp);
	endtask
	task automatic t_reset();
		chk({28'h0, busCtl}, 32'h0000_000f);
		rd(HW_IMPL_CONTROL_0_SPR, 32'h0000_0000);
	endtask
	// bit 5 written as one on purpose: it has no function and is not stored;
	// bits 4 and 6 stay zero as software must keep them
	task automatic t_rw();
		wr(HW_IMPL_CONTROL_0_SPR, 32'hffff_ffaf);
		rd(HW_IMPL_CONTROL_0_SPR, 32'h0000_018f);
		wr(10'h3f1, 32'h0000_0000);
		rd(HW_IMPL_CONTROL_0_SPR, 32'h0000_018f);
		rd(10'h3f1, 32'h0000_0000);
		// write then read on the very next edge: the read sees the new value
		@(posedge sys_clk);
		sprReq <= '{1'b1, 1'b0, HW_IMPL_CONTROL_0_SPR, 32'h0000_0105};
		@(posedge sys_clk);
		sprReq <= '{1'b0, 1'b1, HW_IMPL_CONTROL_0_SPR, 32'h0000_0000};
		@(posedge sys_clk);
		sprReq.rdEn <= 1'b0;
		#1;
		chk(sprRdData, 32'h0000_0105);
	endtask
	task automatic t_busctl();
		logic [8:0] val[4] = '{9'h002, 9'h00e, 9'h006, 9'h080};
		logic [3:0] exp[4] = '{4'h1, 4'h7, 4'h5, 4'he};
		for (int i = 0; i < 4; i++) begin
			wr(HW_IMPL_CONTROL_0_SPR, {23'h0, val[i]});
			chk({28'h0, busCtl}, {28'h0, exp[i]});
		end
	endtask
	// every source, enabled or masked, with exception enable both ways
	task automatic t_err();
		logic [8:0] enBit;
		logic [31:0] got, srr;
		int b;
		for (int k = 0; k < 3; k++) begin
			for (int e = 0; e < 4; e++) begin
				enBit = (k == 0) ? 9'h001 : (k == 1) ? 9'h004 : 9'h008;
				b = (k == 0) ? SAVE_RESTORE_STATUS_1_MCPIN_BIT : (k == 1) ? SAVE_RESTORE_STATUS_1_ADDR_PARITY_BIT : SAVE_RESTORE_STATUS_1_DATA_PARITY_BIT;
				wr(HW_IMPL_CONTROL_0_SPR, {23'h0, e[1] ? enBit : 9'h000});
				@(posedge sys_clk);
				meEn <= e[0];
				got = '0;
				srr = '0;
				fork
					sys.pulse(k);
				join_none
				repeat (10) begin
					@(posedge sys_clk);
					#1;
					if (errOut.mcException === 1'b1 || errOut.checkstop === 1'b1) begin
						got = {30'h0, errOut.mcException, errOut.checkstop};
						srr = errOut.srr1Bits;
					end
				end
				chk(got, {30'h0, e[1] & e[0], e[1] & ~e[0]});
				chk(srr, (e == 3) ? 32'h0000_0001 << b : 32'h0000_0000);
			end
		end
	endtask
	task automatic t_doze();
		wr(HW_IMPL_CONTROL_0_SPR, 32'h0000_0100);
		@(posedge sys_clk);
		lowReq <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk({28'h0, dozeActive, pllRun, timeBaseRun, snoopRun}, 32'h0000_000f);
		wr(HW_IMPL_CONTROL_0_SPR, 32'h0000_0000);
		chk({31'h0, dozeActive}, 32'h0000_0000);
		// doze is a level: dropping the power request must leave it
		wr(HW_IMPL_CONTROL_0_SPR, 32'h0000_0100);
		chk({31'h0, dozeActive}, 32'h0000_0001);
		@(posedge sys_clk);
		lowReq <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk({31'h0, dozeActive}, 32'h0000_0000);
	endtask
	// reset, then the scenarios in turn
	initial begin
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset();
		t_rw();
		t_busctl();
		t_err();
		t_doze();
		end_of_test();
	end
	// whole run is well under a thousand cycles
	initial begin
		#100us;
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
